// [rtl/ppd_input_bank.sv]
`timescale 1ns/1ps
module ppd_input_bank #(
  parameter int unsigned MS_CYCLES = ppd_pkg::MS_TICK_CYCLES,
  parameter logic [31:0] MAP_VERSION = 32'h0001_0001,
  parameter logic [31:0] SERIAL_NUMBER = 32'h0131_EDA1,
  // arbitrary neutral family code
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0A5A,
  parameter logic [31:0] BOARD_REVISION = 32'h0001_0001,
  parameter logic [31:0] LOADER_REVISION = 32'h0004_0001,
  parameter logic [31:0] APP_REVISION = 32'h0000_0001,
  parameter logic [31:0] BUILD_DATE = 32'h0134_3B9D,
  parameter logic [31:0] APP_CHECKSUM = 32'h0000_0000,
  parameter logic [31:0] APP_LENGTH = 32'h0000_2710
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic ce_in,
  input wire logic req_valid_in,
  input wire logic [7:0] req_function_in,
  input wire logic [15:0] req_start_in,
  input wire logic [15:0] req_quantity_in,
  output logic req_ready_out,
  output logic word_valid_out,
  output logic [15:0] word_out,
  output logic word_last_out,
  output logic exception_valid_out,
  output logic [7:0] exception_code_out,
  output logic holding_request_out,
  input wire logic bus_activity_in,
  input wire logic [15:0] timeout_s_in,
  input wire logic [15:0] ref_mv_in,
  input wire logic [15:0] supply_mv_in,
  input wire logic flash_error_in,
  input wire logic flash_write_in,
  input wire logic testing_mode_in,
  input wire logic [4:0] address_switch_in,
  input wire logic [3:0] strap_in,
  input wire logic button_in,
  output logic [6:0] slave_address_out,
  output logic [31:0] status_flags_out
);
  import ppd_pkg::*;

  ppd_time_if time_if ();

  ppd_timebase #(.MS_CYCLES(MS_CYCLES)) timebase (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .ce_in(ce_in),
    .time_if(time_if)
  );

  // pins from outside: two stages before anything reads them
  logic [9:0] pin_meta;
  logic [9:0] pin_sync;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else if (ce_in) begin
      pin_meta <= {button_in, strap_in, address_switch_in};
      pin_sync <= pin_meta;
    end
  end

  logic [15:0] input_levels;
  always_comb begin
    input_levels = '0;
    input_levels[IN_SWITCH_LSB +: 5] = pin_sync[4:0]; // R11
    input_levels[IN_STRAP_LSB +: 4] = pin_sync[8:5]; // R11
    input_levels[IN_BUTTON_BIT] = pin_sync[9]; // R11
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      slave_address_out <= SLAVE_ADDRESS_BASE;
    end else if (ce_in) begin
      slave_address_out <= SLAVE_ADDRESS_BASE + {2'b00, pin_sync[4:0]}; // R21
    end
  end

  // measurements arrive from on-clock converters, no synchroniser needed
  logic [15:0] ref_mv;
  logic [15:0] supply_mv;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ref_mv <= '0;
      supply_mv <= '0;
    end else if (ce_in) begin
      ref_mv <= ref_mv_in; // R4
      supply_mv <= supply_mv_in; // R5
    end
  end

  logic [31:0] flash_writes;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      flash_writes <= '0;
    end else if (ce_in && flash_write_in) begin
      flash_writes <= flash_writes + 32'h1; // R20
    end
  end

  // silence measured in whole seconds; restarts on any received frame
  logic [15:0] silence_s;
  logic link_timeout;
  logic timeout_hit;
  assign timeout_hit = time_if.sec_tick && (timeout_s_in != 16'h0000)
    && (silence_s + 16'h0001 >= timeout_s_in);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      silence_s <= '0;
    end else if (ce_in) begin
      if (bus_activity_in) begin
        silence_s <= '0;
      end else if (time_if.sec_tick && silence_s != 16'hFFFF) begin
        silence_s <= silence_s + 16'h0001;
      end
    end
  end

  // expiry wins over a frame landing in the same cycle
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      link_timeout <= 1'b0;
    end else if (ce_in) begin
      if (timeout_s_in == 16'h0000) begin
        link_timeout <= 1'b0; // R23
      end else if (timeout_hit) begin
        link_timeout <= 1'b1; // R9 R23
      end else if (bus_activity_in) begin
        link_timeout <= 1'b0;
      end
    end
  end

  logic [31:0] next_status;
  always_comb begin
    next_status = '0;
    next_status[ST_FLASH_ERROR] = flash_error_in; // R7
    next_status[ST_LOW_VOLTAGE] = supply_mv_in < SUPPLY_MV_MIN; // R8
    next_status[ST_LINK_TIMEOUT] = link_timeout; // R9
    next_status[ST_TESTING] = testing_mode_in; // R10
    next_status[ST_ANY_ERROR] = flash_error_in || (supply_mv_in < SUPPLY_MV_MIN)
      || link_timeout || testing_mode_in; // R6
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_flags_out <= '0;
    end else if (ce_in) begin
      status_flags_out <= next_status;
    end
  end

  // live values are frozen at acceptance so a 32-bit pair never tears
  logic [31:0] snap_seconds;
  logic [31:0] snap_ms;
  logic [31:0] snap_status;
  logic [31:0] snap_writes;

  function automatic logic [15:0] half_of(input logic [31:0] value, input logic upper);
    half_of = upper ? value[31:16] : value[15:0]; // R24
  endfunction

  function automatic logic [15:0] word_at(input logic [15:0] addr);
    logic [15:0] w;
    w = '0;
    case (addr)
      16'h0000, 16'h0001: w = half_of(snap_seconds, addr == ADDR_UPTIME); // R2
      16'h0002, 16'h0003: w = half_of(MAP_VERSION, addr == ADDR_MAP_VERSION); // R3
      16'h0004: w = ref_mv; // R4
      16'h0005: w = supply_mv; // R5
      16'h0006, 16'h0007: w = half_of(snap_status, addr == ADDR_STATUS);
      16'h0008: w = input_levels; // R11
      16'h0009, 16'h000A: w = half_of(snap_ms, addr == ADDR_MS_COUNT);
      16'h000B, 16'h000C: w = half_of(SERIAL_NUMBER, addr == ADDR_SERIAL); // R12
      16'h000D, 16'h000E: w = half_of(PRODUCT_CODE, addr == ADDR_PRODUCT); // R13
      16'h000F, 16'h0010: w = half_of(BOARD_REVISION, addr == ADDR_BOARD_REV); // R14
      16'h0011, 16'h0012: w = half_of(LOADER_REVISION, addr == ADDR_LOADER_REV); // R15
      16'h0013, 16'h0014: w = half_of(APP_REVISION, addr == ADDR_APP_REV); // R16
      16'h0015, 16'h0016: w = half_of(BUILD_DATE, addr == ADDR_BUILD_DATE); // R17
      16'h0017, 16'h0018: w = half_of(APP_CHECKSUM, addr == ADDR_CHECKSUM); // R18
      16'h0019, 16'h001A: w = half_of(APP_LENGTH, addr == ADDR_APP_LENGTH); // R19
      16'h001B, 16'h001C: w = half_of(snap_writes, addr == ADDR_FLASH_WRITES); // R20
      default: w = '0;
    endcase
    return w;
  endfunction

  ppd_read_state_type state;
  logic [15:0] cursor;
  logic [15:0] remaining;
  logic accept;
  logic fc_known;
  logic qty_bad;
  logic range_bad;
  logic [16:0] last_addr;

  assign req_ready_out = (state == PPD_IDLE);
  assign accept = ce_in && req_valid_in && req_ready_out;
  assign fc_known = (req_function_in == FC_READ_HOLDING)
    || (req_function_in == FC_READ_INPUT) || (req_function_in == FC_WRITE_MULTIPLE);
  assign qty_bad = (req_quantity_in == 16'h0000) || (req_quantity_in > MAX_READ_QUANTITY);
  assign last_addr = {1'b0, req_start_in} + {1'b0, req_quantity_in} - 17'h00001;
  assign range_bad = last_addr > {1'b0, ADDR_LAST};

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      snap_seconds <= '0;
      snap_ms <= '0;
      snap_status <= '0;
      snap_writes <= '0;
    end else if (accept) begin
      snap_seconds <= time_if.sec_count;
      snap_ms <= time_if.ms_count;
      snap_status <= status_flags_out;
      snap_writes <= flash_writes;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state <= PPD_IDLE;
      cursor <= '0;
      remaining <= '0;
    end else if (ce_in) begin
      unique case (state)
        PPD_IDLE: begin
          if (accept && req_function_in == FC_READ_INPUT && !qty_bad && !range_bad) begin
            cursor <= req_start_in;
            remaining <= req_quantity_in;
            state <= PPD_STREAM;
          end
        end
        PPD_STREAM: begin
          cursor <= cursor + 16'h0001;
          remaining <= remaining - 16'h0001;
          if (remaining == 16'h0001) begin
            state <= PPD_IDLE;
          end
        end
        default: state <= PPD_IDLE;
      endcase
    end
  end

  logic word_valid;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      word_valid <= 1'b0;
      word_out <= '0;
      word_last_out <= 1'b0;
    end else if (ce_in) begin
      word_valid <= (state == PPD_STREAM);
      word_last_out <= (state == PPD_STREAM) && (remaining == 16'h0001);
      if (state == PPD_STREAM) begin
        word_out <= word_at(cursor); // R24
      end
    end
  end
  assign word_valid_out = word_valid && ce_in;

  logic exc_valid;
  logic hold_req;
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      exc_valid <= 1'b0;
      exception_code_out <= '0;
      hold_req <= 1'b0;
    end else if (ce_in) begin
      exc_valid <= 1'b0;
      hold_req <= 1'b0;
      if (accept) begin
        if (!fc_known) begin
          exc_valid <= 1'b1;
          exception_code_out <= EXC_ILLEGAL_FUNCTION; // R1
        end else if (req_function_in != FC_READ_INPUT) begin
          hold_req <= 1'b1; // R1 R26
        end else if (qty_bad) begin
          exc_valid <= 1'b1;
          exception_code_out <= EXC_ILLEGAL_VALUE;
        end else if (range_bad) begin
          exc_valid <= 1'b1;
          exception_code_out <= EXC_ILLEGAL_ADDRESS; // R25
        end
      end
    end
  end
  assign exception_valid_out = exc_valid && ce_in;
  assign holding_request_out = hold_req && ce_in;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);

  sequence read_ok_two;
    accept && req_function_in == FC_READ_INPUT && req_quantity_in == 16'h0002
      && !range_bad;
  endsequence
  sequence two_words_out;
    ce_in [*2] ##0 (word_valid_out && !word_last_out) ##1 (word_valid_out && word_last_out);
  endsequence

  AST_BAD_FUNCTION: assert property (accept && !fc_known ##1 ce_in
    |-> exception_valid_out && exception_code_out == 8'h01) // R1
    else $error("unknown function code not refused");
  AST_HOLDING_FORWARD: assert property (accept && req_function_in == FC_WRITE_MULTIPLE
    ##1 ce_in |-> holding_request_out && !word_valid_out) // R26
    else $error("write to input space not forwarded away");
  AST_BAD_ADDRESS: assert property (accept && req_function_in == FC_READ_INPUT
    && !qty_bad && range_bad ##1 ce_in
    |-> exception_code_out == 8'h02 && exception_valid_out) // R25
    else $error("out of map read not refused with address exception");
  AST_PAIR_READ: assert property (read_ok_two |=> two_words_out) // R24
    else $error("two-word read did not stream two words");
  AST_ANY_ERROR: assert property (status_flags_out[0] == |status_flags_out[19:16]) // R6
    else $error("summary error bit disagrees with flags");
  AST_SLAVE_RANGE: assert property (slave_address_out >= 7'h40 && slave_address_out <= 7'h5F) // R21
    else $error("slave address outside base plus switch range");
  AST_LOW_SUPPLY: assert property (ce_in && supply_mv_in < 16'h0FA0 |=> status_flags_out[17]) // R8
    else $error("low supply not flagged");
  AST_WRITE_COUNT: assert property (ce_in && flash_write_in
    |=> flash_writes == $past(flash_writes) + 32'h1) // R20
    else $error("config write counter did not step");
  AST_TIMEOUT_OFF: assert property (timeout_s_in == 16'h0000 && ce_in |=> !link_timeout) // R23
    else $error("timeout flag set while disabled");
endmodule // ppd_input_bank

// [rtl/ppd_pkg.sv]
// Contract
// R1: slave answers function codes 3, 4 and 16 only; others get an exception
// R2: addresses 0 and 1 hold whole seconds since power-up
// R3: map version pair carries major in upper 16 bits, minor in lower 16
// R4: address 4 reports reference voltage in mV, valid 2500 to 3500
// R5: address 5 reports external supply voltage in mV, valid 4000 to 28000
// R6: status bit 0 is set whenever any error flag in the word is set
// R7: status bit 16 is set when a configuration memory operation fails
// R8: status bit 17 is set when supply voltage is too low
// R9: status bit 18 is set after bus silence for the configured timeout
// R10: status bit 19 is set while testing mode is active
// R11: input word: switches bits 0-4, straps bits 5-8, pushbutton bit 9
// R12: serial number pair encodes year, month and four-digit unit number
// R13: product number pair returns one fixed family code on every unit
// R14: hardware version pair: major upper 16 bits, minor lower 16 bits
// R15: bootloader version pair: major upper 16 bits, minor lower 16 bits
// R16: application version pair holds an incrementing revision, 1 to 150
// R17: build date pair holds year, month and day digits as decimal
// R18: checksum pair returns the CRC of the running application image
// R19: length pair reports application size in bytes, 10000 to 28000
// R20: config write counter increments on every config flash write
// R21: slave address is 64 plus the weights of switches turned on
// R22: link defaults to 19200 baud, 8 data bits, even parity, 1 stop
// R23: silence beyond timeout, default 10 s, means lost link; zero disables
// R24: two-address values return upper half at the lower address first
// R25: a read touching an undefined input address gets illegal address
// R26: input registers cannot be written; only read-input reaches them
package ppd_pkg;
  localparam int unsigned CLOCK_HZ = 50_000_000;
  localparam int unsigned MS_PERIOD_US = 1000;
  localparam int unsigned MS_TICK_CYCLES = CLOCK_HZ / 1_000_000 * MS_PERIOD_US;
  localparam int unsigned MS_PER_SECOND = 1000;

  localparam logic [15:0] ADDR_UPTIME = 16'h0000;
  localparam logic [15:0] ADDR_MAP_VERSION = 16'h0002;
  localparam logic [15:0] ADDR_REF_MV = 16'h0004;
  localparam logic [15:0] ADDR_SUPPLY_MV = 16'h0005;
  localparam logic [15:0] ADDR_STATUS = 16'h0006;
  localparam logic [15:0] ADDR_INPUTS = 16'h0008;
  localparam logic [15:0] ADDR_MS_COUNT = 16'h0009;
  localparam logic [15:0] ADDR_SERIAL = 16'h000B;
  localparam logic [15:0] ADDR_PRODUCT = 16'h000D;
  localparam logic [15:0] ADDR_BOARD_REV = 16'h000F;
  localparam logic [15:0] ADDR_LOADER_REV = 16'h0011;
  localparam logic [15:0] ADDR_APP_REV = 16'h0013;
  localparam logic [15:0] ADDR_BUILD_DATE = 16'h0015;
  localparam logic [15:0] ADDR_CHECKSUM = 16'h0017;
  localparam logic [15:0] ADDR_APP_LENGTH = 16'h0019;
  localparam logic [15:0] ADDR_FLASH_WRITES = 16'h001B;
  localparam logic [15:0] ADDR_LAST = 16'h001C;

  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_MULTIPLE = 8'h10;
  localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] MAX_READ_QUANTITY = 16'h007D;

  localparam int unsigned ST_ANY_ERROR = 0;
  localparam int unsigned ST_FLASH_ERROR = 16;
  localparam int unsigned ST_LOW_VOLTAGE = 17;
  localparam int unsigned ST_LINK_TIMEOUT = 18;
  localparam int unsigned ST_TESTING = 19;
  localparam int unsigned IN_SWITCH_LSB = 0;
  localparam int unsigned IN_STRAP_LSB = 5;
  localparam int unsigned IN_BUTTON_BIT = 9;

  localparam logic [6:0] SLAVE_ADDRESS_BASE = 7'h40;
  localparam int unsigned LINK_BAUD = 19200; // R22
  localparam int unsigned LINK_DATA_BITS = 8;
  localparam bit LINK_PARITY_EVEN = 1'b1;
  localparam int unsigned LINK_STOP_BITS = 1;
  localparam logic [15:0] TIMEOUT_DEFAULT_S = 16'h000A;
  localparam logic [15:0] TIMEOUT_MAX_S = 16'h1C20;

  localparam logic [15:0] REF_MV_MIN = 16'h09C4;
  localparam logic [15:0] REF_MV_MAX = 16'h0DAC;
  localparam logic [15:0] SUPPLY_MV_MIN = 16'h0FA0;
  localparam logic [15:0] SUPPLY_MV_MAX = 16'h6D60;

  typedef enum logic [1:0] {
    PPD_IDLE = 2'b00,
    PPD_STREAM = 2'b01
  } ppd_read_state_type;
endpackage

// [rtl/ppd_time_if.sv]
`timescale 1ns/1ps
interface ppd_time_if;
  logic ms_tick;
  logic sec_tick;
  logic [31:0] ms_count;
  logic [31:0] sec_count;
  modport timer (output ms_tick, output sec_tick, output ms_count, output sec_count);
  modport user (input ms_tick, input sec_tick, input ms_count, input sec_count);
endinterface

// [rtl/ppd_timebase.sv]
`timescale 1ns/1ps
module ppd_timebase #(
  parameter int unsigned MS_CYCLES = ppd_pkg::MS_TICK_CYCLES
) (
  input wire logic clock_in,
  input wire logic reset_in,
  input wire logic ce_in,
  ppd_time_if.timer time_if
);
  import ppd_pkg::*;
  localparam int unsigned PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam logic [PW-1:0] PRESCALE_END = PW'(MS_CYCLES - 1);
  localparam logic [9:0] MS_IN_SEC_END = 10'(MS_PER_SECOND - 1);

  logic [PW-1:0] prescale;
  logic [9:0] ms_in_sec;
  logic ms_wrap;
  logic sec_wrap;

  assign ms_wrap = ce_in && (prescale == PRESCALE_END);
  assign sec_wrap = ms_wrap && (ms_in_sec == MS_IN_SEC_END);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      prescale <= '0;
    end else if (ce_in) begin
      prescale <= ms_wrap ? '0 : prescale + 1'b1;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ms_in_sec <= '0;
      time_if.ms_count <= '0;
    end else if (ms_wrap) begin
      ms_in_sec <= sec_wrap ? '0 : ms_in_sec + 1'b1;
      time_if.ms_count <= time_if.ms_count + 1'b1;
    end
  end

  // seconds derive from the same ms chain so both never drift apart
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      time_if.sec_count <= '0;
    end else if (sec_wrap) begin
      time_if.sec_count <= time_if.sec_count + 1'b1; // R2
    end
  end

  assign time_if.ms_tick = ms_wrap;
  assign time_if.sec_tick = sec_wrap;

  AST_UPTIME_STEP: assert property (@(posedge clock_in) disable iff (reset_in)
    sec_wrap |=> time_if.sec_count == $past(time_if.sec_count) + 32'h1) // R2
    else $error("uptime did not advance on second tick");
endmodule // ppd_timebase

// [verification/ppd_master_model.sv]
`timescale 1ns/1ps
// frames arrive already decoded; link format stays at the package defaults
module ppd_master_model (
  input wire logic clock_in,
  input wire logic req_ready_in,
  input wire logic word_valid_in,
  input wire logic [15:0] word_in,
  input wire logic word_last_in,
  input wire logic exception_valid_in,
  input wire logic [7:0] exception_code_in,
  input wire logic holding_request_in,
  output logic req_valid_out,
  output logic [7:0] req_function_out,
  output logic [15:0] req_start_out,
  output logic [15:0] req_quantity_out
);
  logic [15:0] words[$];
  logic [7:0] exc_code;
  bit got_exc;
  bit got_hold;
  bit got_last;
  time taken_at;
  initial begin
    req_valid_out = 1'b0;
    req_function_out = 8'h00;
    req_start_out = 16'h0000;
    req_quantity_out = 16'h0000;
  end
  task automatic transact(input logic [7:0] fc, input logic [15:0] start,
      input logic [15:0] qty);
    words.delete();
    got_exc = 1'b0;
    got_hold = 1'b0;
    got_last = 1'b0;
    @(posedge clock_in);
    // random idle gap, zero gives back-to-back requests
    repeat ($urandom_range(2, 0)) @(posedge clock_in);
    req_valid_out <= 1'b1;
    req_function_out <= fc;
    req_start_out <= start;
    req_quantity_out <= qty;
    do @(posedge clock_in); while (req_ready_in !== 1'b1);
    taken_at = $time;
    req_valid_out <= 1'b0;
    // released fields scrambled so stale values cannot pass
    req_function_out <= ~fc;
    req_start_out <= ~start;
    req_quantity_out <= ~qty;
    for (int n = 0; n < int'(qty) + 4 && !got_last && !got_exc && !got_hold; n++) begin
      @(negedge clock_in);
      if (word_valid_in === 1'b1) begin
        words.push_back(word_in);
        got_last = word_last_in === 1'b1;
      end
      got_exc = exception_valid_in === 1'b1;
      got_hold = holding_request_in === 1'b1;
      exc_code = exception_code_in;
    end
  endtask
endmodule // ppd_master_model

// [verification/ppd_input_bank_tb.sv]
`timescale 1ns/1ps
module ppd_input_bank_tb;
  import ppd_pkg::*;
  localparam int unsigned MSC = 5;
  // arbitrary identity and version words, in map order
  localparam logic [31:0] IDV [0:8] = '{32'h0002_0003, 32'h0132_0007, 32'h0000_0C3C,
    32'h0002_0001, 32'h0004_0002, 32'h0000_0011, 32'h0134_4F2E, 32'h1234_ABCD, 32'h0000_3A98};
  logic clock_in = 1'b0;
  logic reset_in = 1'b1;
  logic req_valid, req_ready, word_valid, word_last, exc_valid, hold_req;
  logic [7:0] req_fc, exc_code;
  logic [15:0] req_start, req_qty, word;
  logic [6:0] slave_address_out;
  logic [31:0] status_flags_out;
  logic [15:0] ref_mv, sup_mv, tout_s;
  logic flash_err, flash_wr, testing, bus_act, btn;
  logic ce = 1'b1;
  logic [4:0] sw;
  logic [3:0] strap;
  logic [7:0] fc;
  logic [15:0] exp_map [0:28];
  int bad_count = 0;
  int check_count = 0;
  int cyc = 0;
  int writes = 0;
  bit tout_exp = 1'b0;
  time release_at;

  ppd_input_bank #(.MS_CYCLES(MSC), .MAP_VERSION(IDV[0]), .SERIAL_NUMBER(IDV[1]),
    .PRODUCT_CODE(IDV[2]), .BOARD_REVISION(IDV[3]), .LOADER_REVISION(IDV[4]),
    .APP_REVISION(IDV[5]), .BUILD_DATE(IDV[6]), .APP_CHECKSUM(IDV[7]),
    .APP_LENGTH(IDV[8])) ppd_input_bank_i (
    .clock_in(clock_in), .reset_in(reset_in), .ce_in(ce),
    .req_valid_in(req_valid), .req_function_in(req_fc), .req_start_in(req_start),
    .req_quantity_in(req_qty), .req_ready_out(req_ready), .word_valid_out(word_valid),
    .word_out(word), .word_last_out(word_last), .exception_valid_out(exc_valid),
    .exception_code_out(exc_code), .holding_request_out(hold_req),
    .bus_activity_in(bus_act), .timeout_s_in(tout_s), .ref_mv_in(ref_mv),
    .supply_mv_in(sup_mv), .flash_error_in(flash_err), .flash_write_in(flash_wr),
    .testing_mode_in(testing), .address_switch_in(sw), .strap_in(strap),
    .button_in(btn), .slave_address_out(slave_address_out),
    .status_flags_out(status_flags_out));

  ppd_master_model ppd_master_model_i (
    .clock_in(clock_in), .req_ready_in(req_ready), .word_valid_in(word_valid),
    .word_in(word), .word_last_in(word_last), .exception_valid_in(exc_valid),
    .exception_code_in(exc_code), .holding_request_in(hold_req),
    .req_valid_out(req_valid), .req_function_out(req_fc), .req_start_out(req_start),
    .req_quantity_out(req_qty));

  always #10 clock_in = ~clock_in;

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, the run needs about 22300 cycles
  always @(posedge clock_in) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] status_exp();
    logic [31:0] s;
    s = 32'h0;
    s[ST_FLASH_ERROR] = flash_err;
    s[ST_LOW_VOLTAGE] = sup_mv < SUPPLY_MV_MIN;
    s[ST_LINK_TIMEOUT] = tout_exp;
    s[ST_TESTING] = testing;
    s[ST_ANY_ERROR] = |s;
    return s;
  endfunction

  task automatic put32(input int a, input logic [31:0] v);
    exp_map[a] = v[31:16];
    exp_map[a + 1] = v[15:0];
  endtask

  task automatic read_check(input int start, input int qty);
    logic [31:0] ms;
    logic [31:0] est;
    ppd_master_model_i.transact(FC_READ_INPUT, start[15:0], qty[15:0]);
    est = 32'((ppd_master_model_i.taken_at - release_at) / 20 / MSC);
    ms = est;
    // uptime is judged against the tick read in the same snapshot
    if (start <= 9 && start + qty >= 11) begin
      ms = {ppd_master_model_i.words[9 - start], ppd_master_model_i.words[10 - start]};
      check_bits({31'h0, ms + 1 >= est && ms <= est + 1}, 32'h1);
    end
    put32(0, ms / 1000);
    put32(9, ms);
    put32(2, IDV[0]);
    for (int i = 1; i < 9; i++) put32(9 + 2 * i, IDV[i]);
    exp_map[4] = ref_mv;
    exp_map[5] = sup_mv;
    put32(6, status_exp());
    exp_map[8] = {6'h00, btn, strap, sw};
    put32(27, writes);
    check_bits(32'(ppd_master_model_i.words.size()), 32'(qty));
    for (int i = 0; i < qty && i < ppd_master_model_i.words.size(); i++)
      check_word(ppd_master_model_i.words[i], exp_map[start + i]);
  endtask

  // code 00 means the request must go to the holding bank
  task automatic expect_exc(input logic [7:0] f, input int start, input int qty,
      input logic [7:0] code);
    ppd_master_model_i.transact(f, start[15:0], qty[15:0]);
    check_bits(32'(ppd_master_model_i.words.size()), 32'h0);
    if (code == 8'h00) begin
      check_bits({31'h0, ppd_master_model_i.got_hold}, 32'h1);
    end else begin
      check_bits({31'h0, ppd_master_model_i.got_exc}, 32'h1);
      check_code(ppd_master_model_i.exc_code, code);
    end
  endtask

  initial begin
    void'($urandom(32'h3607));
    ref_mv = 16'(2500 + $urandom_range(1000, 0));
    sup_mv = 16'(4000 + $urandom_range(24000, 0));
    sw = 5'($urandom);
    strap = 4'($urandom);
    btn = 1'($urandom);
    tout_s = 16'h0000;
    flash_err = 1'b0;
    flash_wr = 1'b0;
    testing = 1'b0;
    bus_act = 1'b0;
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    release_at = $time;
    repeat (4) @(posedge clock_in);
    check_bits({25'h0, slave_address_out}, 32'd64 + 32'(sw));
    // 50 frozen cycles: the tick must not count them, so shift the time origin
    ce <= 1'b0;
    repeat (50) @(posedge clock_in);
    ce <= 1'b1;
    release_at += 1000;
    repeat ($urandom_range(6, 2)) begin
      @(posedge clock_in);
      flash_wr <= 1'b1;
      writes++;
      @(posedge clock_in);
      flash_wr <= 1'b0;
    end
    read_check(0, 29);
    for (int i = 0; i < 5; i++) begin
      @(posedge clock_in);
      flash_err <= i == 1;
      testing <= i == 2;
      sup_mv <= (i == 3) ? 16'h0F9F : (i == 4) ? 16'h0FA0 : sup_mv;
      repeat (3) @(posedge clock_in);
      check_bits(status_flags_out, status_exp());
      if (i == 3) read_check(4, 5);
    end
    repeat (11000) @(posedge clock_in);
    check_bits(status_flags_out, status_exp());
    tout_s <= 16'h0001;
    repeat (11000) @(posedge clock_in);
    tout_exp = 1'b1;
    check_bits(status_flags_out, status_exp());
    read_check(0, 11);
    @(posedge clock_in);
    bus_act <= 1'b1;
    @(posedge clock_in);
    bus_act <= 1'b0;
    tout_exp = 1'b0;
    repeat (2) @(posedge clock_in);
    check_bits(status_flags_out, status_exp());
    for (int i = 0; i < 8; i++) begin
      fc = 8'($urandom);
      if (fc != FC_READ_HOLDING && fc != FC_READ_INPUT && fc != FC_WRITE_MULTIPLE)
        expect_exc(fc, 0, 1, EXC_ILLEGAL_FUNCTION);
    end
    expect_exc(FC_READ_HOLDING, 0, 2, 8'h00);
    expect_exc(FC_WRITE_MULTIPLE, 0, 2, 8'h00);
    expect_exc(FC_READ_INPUT, 0, 0, EXC_ILLEGAL_VALUE);
    expect_exc(FC_READ_INPUT, 0, 126, EXC_ILLEGAL_VALUE);
    expect_exc(FC_READ_INPUT, 28, 2, EXC_ILLEGAL_ADDRESS);
    expect_exc(FC_READ_INPUT, 0, 125, EXC_ILLEGAL_ADDRESS);
    expect_exc(FC_READ_INPUT, 256, 1, EXC_ILLEGAL_ADDRESS);
    read_check(13, 2);
    read_check(28, 1);
    summarize();
  end
endmodule // ppd_input_bank_tb
